// File: common/ebba_consts.vh
// constants for the beep and blink annunciator
// assumes a 100 MHz reference clock; all timing derives from it
`ifndef EBBA_CONSTS_VH
`define EBBA_CONSTS_VH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define EBBA_CLK_HZ        100000000
`define EBBA_TICK_HZ       4
// cycles per quarter second (least time, exact here)
`define EBBA_TICK_CYC      (`EBBA_CLK_HZ / `EBBA_TICK_HZ)

// ----------------------------------------------------------------
// tone frequencies in hertz
// ----------------------------------------------------------------
`define EBBA_TONE_PROMPT_HZ 932
`define EBBA_TONE_HIGH_HZ   2000
`define EBBA_TONE_LOW_HZ    1500

// ----------------------------------------------------------------
// pattern step lengths in quarter-second ticks
// ----------------------------------------------------------------
`define EBBA_Q_PROMPT      3'h2
`define EBBA_Q_UPDATE      3'h2
`define EBBA_Q_ERR_STEP    3'h4
`define EBBA_Q_PAUSE       4'hA
`define EBBA_Q_THERM_STEP  3'h1

// ----------------------------------------------------------------
// pattern counts
// ----------------------------------------------------------------
`define EBBA_VID_PULSES    4'h2
`define EBBA_MEM_PULSES    4'h3
`define EBBA_VID_ROUNDS    2'h2
`define EBBA_THERM_TONES   4'h8

`endif

// File: logic/ebba_annunciator.v
// beep and blink annunciator for power-on self-test conditions
// assumes condition inputs come from firmware logic on i_ref_clk;
// speaker and led are plain push-pull outputs
//
// Contract
// - prompt: one half-second 932 Hz tone, led left unchanged
// - update: speaker silent, led off, then 0.5 s on / 0.5 s off
// - video: tone on/off 1 s twice, 2.5 s pause, played twice
// - video: led on/off 1 s twice, 2.5 s off, forever
// - memory: tone on/off 1 s three times, 2.5 s pause, forever
// - memory: led on/off 1 s three times, 2.5 s off, forever
// - thermal: eight 1 s tones alternating 2000/1500 Hz, then shutdown
// - thermal: led on/off twice per tone in quarter seconds
`timescale 1ns/1ps
`default_nettype none
`include "ebba_consts.vh"

module ebba_annunciator #(
  parameter integer TICK_CYC  = `EBBA_TICK_CYC,
  parameter integer CLK_HZ    = `EBBA_CLK_HZ
) (
  // clock and reset
  input  wire i_ref_clk,
  input  wire i_reset,
  // condition reports from firmware
  input  wire i_prompt_pulse,
  input  wire i_update_active,
  input  wire i_video_err,
  input  wire i_memory_err,
  input  wire i_thermal_trip,
  // outputs to speaker, led and power control
  output reg  o_speaker,
  output reg  o_led,
  output reg  o_shutdown_req,
  output reg  o_boot_continue
);

  // --------------------------------------------------------------
  // states
  // --------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_PROMPT = 3'h1;
  localparam [2:0] ST_UPDATE = 3'h2;
  localparam [2:0] ST_ERR    = 3'h3;
  localparam [2:0] ST_THERM  = 3'h4;
  localparam [2:0] ST_HALT   = 3'h5;

  // half-period counts for each tone
  localparam integer HALF_PROMPT = CLK_HZ / (2 * `EBBA_TONE_PROMPT_HZ);
  localparam integer HALF_HIGH   = CLK_HZ / (2 * `EBBA_TONE_HIGH_HZ);
  localparam integer HALF_LOW    = CLK_HZ / (2 * `EBBA_TONE_LOW_HZ);

  function [16:0] half_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h1:    half_of = HALF_HIGH[16:0];
        2'h2:    half_of = HALF_LOW[16:0];
        default: half_of = HALF_PROMPT[16:0];
      endcase
    end
  endfunction

  reg  [2:0]  state_reg;
  reg  [24:0] tick_cnt_reg;
  reg         tick_reg;
  reg  [3:0]  step_q_reg;     // ticks left in this step
  reg  [3:0]  pulse_reg;      // pulses done in current round
  reg         phase_on_reg;   // on or off half of a pulse
  reg         in_pause_reg;
  reg  [1:0]  round_reg;
  reg         is_mem_reg;     // memory pattern, else video
  reg         vid_beeps_reg;  // video tones still allowed
  reg  [3:0]  tone_cnt_reg;
  reg         tone_en_reg;
  reg  [1:0]  tone_sel_reg;
  reg  [16:0] div_reg;
  reg         sq_reg;

  // --------------------------------------------------------------
  // quarter-second tick
  // --------------------------------------------------------------
  // step time base
  always @(posedge i_ref_clk) begin
    if (i_reset || state_reg == ST_IDLE) begin
      tick_cnt_reg <= 25'h0000000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_CYC[24:0] - 25'h0000001) begin
      tick_cnt_reg <= 25'h0000000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 25'h0000001;
      tick_reg     <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // tone divider
  // --------------------------------------------------------------
  // square wave divider, fifty percent duty
  always @(posedge i_ref_clk) begin
    if (i_reset || !tone_en_reg) begin
      div_reg <= 17'h00000;
      sq_reg  <= 1'b0;
    end else if (div_reg >= half_of(tone_sel_reg) - 17'h00001) begin
      div_reg <= 17'h00000;
      sq_reg  <= ~sq_reg;
    end else begin
      div_reg <= div_reg + 17'h00001;
    end
  end

  // --------------------------------------------------------------
  // pattern sequencer
  // --------------------------------------------------------------
  // one sequencer keeps speaker and led in step; the video tone
  // stops after two rounds while its led keeps going
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg       <= ST_IDLE;
      step_q_reg      <= 4'h0;
      pulse_reg       <= 4'h0;
      phase_on_reg    <= 1'b0;
      in_pause_reg    <= 1'b0;
      round_reg       <= 2'h0;
      is_mem_reg      <= 1'b0;
      vid_beeps_reg   <= 1'b0;
      tone_cnt_reg    <= 4'h0;
      tone_en_reg     <= 1'b0;
      tone_sel_reg    <= 2'h0;
      o_speaker       <= 1'b0;
      o_led           <= 1'b0;
      o_shutdown_req  <= 1'b0;
      o_boot_continue <= 1'b0;
    end else begin
      o_speaker <= tone_en_reg & sq_reg;
      if (i_thermal_trip && state_reg != ST_THERM &&
          state_reg != ST_HALT) begin
        state_reg    <= ST_THERM;
        tone_cnt_reg <= 4'h0;
        tone_sel_reg <= 2'h1;
        tone_en_reg  <= 1'b1;
        pulse_reg    <= 4'h0;
        step_q_reg   <= {1'b0, `EBBA_Q_THERM_STEP};
        o_led        <= 1'b1;
      end else if ((i_memory_err || i_video_err) &&
                   (state_reg == ST_IDLE || state_reg == ST_PROMPT ||
                    state_reg == ST_UPDATE)) begin
        state_reg     <= ST_ERR;
        is_mem_reg    <= i_memory_err;
        vid_beeps_reg <= 1'b1;
        round_reg     <= 2'h0;
        pulse_reg     <= 4'h0;
        phase_on_reg  <= 1'b1;
        in_pause_reg  <= 1'b0;
        step_q_reg    <= {1'b0, `EBBA_Q_ERR_STEP};
        tone_sel_reg  <= 2'h0;
        tone_en_reg   <= 1'b1;
        o_led         <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (i_update_active) begin
              state_reg    <= ST_UPDATE;
              o_led        <= 1'b0;
              phase_on_reg <= 1'b0;
              tone_en_reg  <= 1'b0;
              step_q_reg   <= {1'b0, `EBBA_Q_UPDATE};
            end else if (i_prompt_pulse) begin
              state_reg    <= ST_PROMPT;
              tone_sel_reg <= 2'h0;
              tone_en_reg  <= 1'b1;
              step_q_reg   <= {1'b0, `EBBA_Q_PROMPT};
            end
          end
          ST_PROMPT: begin
            if (tick_reg) begin
              if (step_q_reg == 4'h1) begin
                state_reg   <= ST_IDLE;
                tone_en_reg <= 1'b0;
              end else begin
                step_q_reg <= step_q_reg - 4'h1;
              end
            end
          end
          ST_UPDATE: begin
            if (!i_update_active) begin
              state_reg <= ST_IDLE;
              o_led     <= 1'b0;
            end else if (tick_reg) begin
              if (step_q_reg == 4'h1) begin
                step_q_reg   <= {1'b0, `EBBA_Q_UPDATE};
                phase_on_reg <= ~phase_on_reg;
                o_led        <= ~phase_on_reg;
              end else begin
                step_q_reg <= step_q_reg - 4'h1;
              end
            end
          end
          ST_ERR: begin
            if (tick_reg) begin
              if (step_q_reg != 4'h1) begin
                step_q_reg <= step_q_reg - 4'h1;
              end else if (in_pause_reg) begin
                in_pause_reg <= 1'b0;
                phase_on_reg <= 1'b1;
                pulse_reg    <= 4'h0;
                step_q_reg   <= {1'b0, `EBBA_Q_ERR_STEP};
                o_led        <= 1'b1;
                tone_en_reg  <= is_mem_reg | vid_beeps_reg;
              end else if (phase_on_reg) begin
                phase_on_reg <= 1'b0;
                step_q_reg   <= {1'b0, `EBBA_Q_ERR_STEP};
                o_led        <= 1'b0;
                tone_en_reg  <= 1'b0;
                pulse_reg    <= pulse_reg + 4'h1;
              end else if (pulse_reg == (is_mem_reg ? `EBBA_MEM_PULSES
                                                    : `EBBA_VID_PULSES))
              begin
                in_pause_reg <= 1'b1;
                step_q_reg   <= `EBBA_Q_PAUSE;
                if (!is_mem_reg && round_reg == `EBBA_VID_ROUNDS - 2'h1)
                begin
                  // two video rounds heard, boot goes on
                  vid_beeps_reg   <= 1'b0;
                  o_boot_continue <= 1'b1;
                end
                round_reg <= (round_reg == 2'h3) ? round_reg
                                                 : round_reg + 2'h1;
              end else begin
                phase_on_reg <= 1'b1;
                step_q_reg   <= {1'b0, `EBBA_Q_ERR_STEP};
                o_led        <= 1'b1;
                tone_en_reg  <= is_mem_reg | vid_beeps_reg;
              end
            end
          end
          ST_THERM: begin
            // quarter-second led toggles within each tone
            if (tick_reg) begin
              // even quarters end an on step, odd ones an off step, so
              // every tone opens lit and closes dark
              o_led     <= pulse_reg[0];
              pulse_reg <= pulse_reg + 4'h1;
              if (pulse_reg[1:0] == 2'h3) begin
                // tone done, alternate or shut down
                if (tone_cnt_reg == `EBBA_THERM_TONES - 4'h1) begin
                  state_reg      <= ST_HALT;
                  tone_en_reg    <= 1'b0;
                  o_led          <= 1'b0;
                  o_shutdown_req <= 1'b1;
                end else begin
                  tone_cnt_reg <= tone_cnt_reg + 4'h1;
                  tone_sel_reg <= tone_cnt_reg[0] ? 2'h1 : 2'h2;
                end
              end
            end
          end
          ST_HALT: begin
            o_shutdown_req <= 1'b1;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: test/ebba_annunciator_asserts.sv
// checker on the annunciator ports, bound into the design
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module ebba_chk #(
  parameter integer TICK_CYC = 20,
  parameter integer CLK_HZ   = 20000
) (
  input wire logic i_ref_clk, i_reset,
  input wire logic i_prompt_pulse, i_update_active, i_video_err,
  input wire logic i_memory_err, i_thermal_trip,
  input wire logic o_speaker, o_led, o_shutdown_req, o_boot_continue
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic any_reg, th_reg, vd_reg;
  int   th_cnt_reg, vd_cnt_reg, lo_cnt_reg;
  // sticky causes, cycles since the thermal and video causes, low run of the speaker
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      {any_reg, th_reg, vd_reg} <= 3'h0;
      th_cnt_reg <= 0;
      vd_cnt_reg <= 0;
    end else begin
      any_reg <= any_reg | i_prompt_pulse | i_update_active | i_video_err
                 | i_memory_err | i_thermal_trip;
      th_reg <= th_reg | i_thermal_trip;
      vd_reg <= vd_reg | i_video_err;
      th_cnt_reg <= th_cnt_reg + int'(th_reg | i_thermal_trip);
      vd_cnt_reg <= vd_cnt_reg + int'(vd_reg | i_video_err);
    end
    // preset long so the first tone after reset is not flagged
    lo_cnt_reg <= i_reset ? 1000 : (o_speaker ? 0 : lo_cnt_reg + 1);
  end
  sequence s_shut_held;
    o_shutdown_req [*3];
  endsequence
  AST_RST_QUIET:
    assert property (disable iff (1'b0) i_reset |=> !(o_speaker | o_led
      | o_shutdown_req | o_boot_continue)) else $error("reset left output");
  AST_SHUT_HOLD:
    assert property (o_shutdown_req |=> o_shutdown_req)
      else $error("shutdown request dropped");
  AST_BOOT_HOLD:
    assert property (o_boot_continue |=> o_boot_continue)
      else $error("boot continue dropped");
  AST_SHUT_QUIET:
    assert property (s_shut_held |-> !o_speaker && !o_led)
      else $error("activity after shutdown");
  AST_SHUT_TIME:
    assert property ($rose(o_shutdown_req) |-> th_reg
      && th_cnt_reg >= 31 * TICK_CYC && th_cnt_reg <= 34 * TICK_CYC)
      else $error("shutdown off time");
  AST_BOOT_TIME:
    assert property ($rose(o_boot_continue) |-> vd_reg
      && vd_cnt_reg >= 40 * TICK_CYC && vd_cnt_reg <= 44 * TICK_CYC)
      else $error("boot continue off time");
  AST_IDLE_QUIET:
    assert property (!any_reg |-> !o_speaker && !o_led)
      else $error("output with no condition");
  AST_TONE_HALF:
    assert property ($rose(o_speaker) |-> lo_cnt_reg >= CLK_HZ / 4000 - 1)
      else $error("tone half too short");
  // the last thermal tone ends on a dark quarter before shutdown
  AST_SHUT_AFTER_DARK:
    assert property ($rose(o_shutdown_req) |-> !$past(o_led, 2))
      else $error("thermal blink not dark before shutdown");
endmodule
bind ebba_annunciator ebba_chk #(.TICK_CYC(TICK_CYC), .CLK_HZ(CLK_HZ))
  u_ebba_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_prompt_pulse(i_prompt_pulse), .i_update_active(i_update_active),
  .i_video_err(i_video_err), .i_memory_err(i_memory_err),
  .i_thermal_trip(i_thermal_trip), .o_speaker(o_speaker), .o_led(o_led),
  .o_shutdown_req(o_shutdown_req), .o_boot_continue(o_boot_continue));
`default_nettype wire

// File: test/ebba_panel_model.sv
// speaker and power led model: counts rising edges of each
// assumes both are sampled on the reference clock
`timescale 1ns/1ps
`default_nettype none
module ebba_panel_model (
  input  wire logic i_ref_clk,
  input  wire logic i_clear,
  input  wire logic i_speaker,
  input  wire logic i_led,
  output var int    o_spk_rises,
  output var int    o_led_rises
);
  logic spk_d_reg, led_d_reg;
  // a piezo only sounds on edges, so rises stand for tone cycles
  always @(posedge i_ref_clk) begin
    spk_d_reg <= i_speaker;
    led_d_reg <= i_led;
    if (i_clear) begin
      o_spk_rises <= 0;
      o_led_rises <= 0;
    end else begin
      o_spk_rises <= o_spk_rises + int'(i_speaker && !spk_d_reg);
      o_led_rises <= o_led_rises + int'(i_led && !led_d_reg);
    end
  end
endmodule
`default_nettype wire

// File: test/error_beep_blink_annunciator_tb_top.sv
// testbench: one task per pattern, judged by edge counts
// assumes scaled time: TC cycles per quarter second
`timescale 1ns/1ps
`default_nettype none
module error_beep_blink_annunciator_tb_top;
  localparam integer TC = 100;
  localparam integer HZ = 20000;
  localparam integer SEC = 4 * TC;
  logic clk = 1'b0, rst = 1'b1, clr = 1'b1;
  logic prm = 1'b0, upd = 1'b0, vid = 1'b0, mem = 1'b0, thr = 1'b0;
  wire  spk, led, shut, boot;
  int   spk_n, led_n, bad_count = 0, checks_done = 0, cyc = 0;
  always #5 clk = ~clk;
  ebba_annunciator #(.TICK_CYC(TC), .CLK_HZ(HZ)) u_ebba_annunciator (
    .i_ref_clk(clk), .i_reset(rst), .i_prompt_pulse(prm),
    .i_update_active(upd), .i_video_err(vid), .i_memory_err(mem),
    .i_thermal_trip(thr), .o_speaker(spk), .o_led(led),
    .o_shutdown_req(shut), .o_boot_continue(boot));
  ebba_panel_model u_ebba_panel_model (.i_ref_clk(clk), .i_clear(clr),
    .i_speaker(spk), .i_led(led), .o_spk_rises(spk_n), .o_led_rises(led_n));
  // ----------------
  // helpers
  // ----------------
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[ERR] %0t count %0d not %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * TC) @(negedge clk);
  endtask
  task automatic zero;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask
  // reset for 6 cycles; error patterns end only by reset or a thermal trip, thermal only by reset
  task automatic restart;
    {prm, upd, vid, mem, thr} = 5'h00;
    rst = 1'b1;
    clr = 1'b1;
    repeat (6) @(negedge clk);
    {rst, clr} = 2'h0;
  endtask
  // rises in n cycles: the divider can only make whole half periods,
  // so the scaled clock lands a little off the nominal pitch
  function automatic int tone(input int n, input int hz);
    return n / (2 * (HZ / (2 * hz)));
  endfunction
  task automatic t_prompt;
    restart();
    prm = 1'b1;
    @(negedge clk);
    prm = 1'b0;
    ticks(3);
    chk_rng(spk_n, tone(SEC / 2, 932) - 2, tone(SEC / 2, 932) + 1);
    chk_rng(led_n, 0, 0);
  endtask
  task automatic t_update;
    restart();
    upd = 1'b1;
    repeat (TC / 2) @(negedge clk);
    chk_bit(led, 1'b0);
    ticks(7);
    chk_rng(led_n, 2, 2);
    chk_rng(spk_n, 0, 0);
    upd = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(led, 1'b0);
  endtask
  // video: two rounds sound, blink forever
  task automatic t_video;
    restart();
    vid = 1'b1;
    @(negedge clk);
    vid = 1'b0;
    for (int i = 0; i < 46 * TC && boot !== 1'b1; i++) @(negedge clk);
    chk_bit(boot, 1'b1);
    chk_rng(led_n, 4, 4);
    chk_rng(spk_n, tone(4 * SEC, 932) - 4, tone(4 * SEC, 932) + 2);
    zero();
    ticks(26);
    chk_rng(spk_n, 0, 0);
    chk_rng(led_n, 2, 2);
  endtask
  task automatic t_memory;
    restart();
    {mem, vid} = 2'h3;
    @(negedge clk);
    {mem, vid} = 2'h0;
    ticks(66);
    chk_rng(led_n, 6, 6);
    chk_rng(spk_n, tone(6 * SEC, 932) - 6, tone(6 * SEC, 932) + 2);
    chk_bit(boot, 1'b0);
  endtask
  task automatic t_thermal;
    int e;
    restart();
    {thr, mem} = 2'h3;
    @(negedge clk);
    {thr, mem} = 2'h0;
    // second quarter of the first tone is dark, the third lit
    repeat (TC + TC / 2) @(negedge clk);
    chk_bit(led, 1'b0);
    repeat (TC) @(negedge clk);
    chk_bit(led, 1'b1);
    for (int i = 0; i < 36 * TC && shut !== 1'b1; i++) @(negedge clk);
    e = tone(4 * SEC, 2000) + tone(4 * SEC, 1500);
    chk_bit(shut, 1'b1);
    chk_rng(led_n, 16, 16);
    // pitch swaps keep the divider phase, so allow a few edges of slack
    chk_rng(spk_n, e - 10, e + 6);
    repeat (3) @(negedge clk);
    chk_bit(led, 1'b0);
    zero();
    prm = 1'b1;
    @(negedge clk);
    prm = 1'b0;
    ticks(2);
    chk_rng(spk_n, 0, 0);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    t_prompt();
    t_update();
    t_video();
    t_memory();
    t_thermal();
    give_verdict();
  end
  // hang guard: the run needs about 20000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
